// ===== gpio_pkg.sv
// package: constants and carriers for the general purpose pin port
package gpio_pkg;

    localparam int unsigned PIN_COUNT      = 16;
    localparam int unsigned IRQ_PIN_COUNT  = 13;
    localparam int unsigned CLK_PIN_A      = 14;
    localparam int unsigned CLK_PIN_B      = 15;
    localparam int unsigned DIV_WIDTH      = 8;

    // reset values
    localparam logic [15:0] DIR_OUT_RST    = 16'h0000;
    localparam logic [15:0] OUT_VAL_RST    = 16'h0000;
    localparam logic [12:0] IRQ_EN_RST     = 13'h0000;
    localparam logic        CLK_SEL_A_RST  = 1'b0;
    localparam logic        CLK_SEL_B_RST  = 1'b1;
    localparam logic [7:0]  PERIOD_RST     = 8'h01;
    localparam logic [7:0]  HIGH_RST       = 8'h01;
    localparam logic [7:0]  COUNT_ONE      = 8'h01;
    localparam logic [7:0]  COUNT_ZERO     = 8'h00;

    // clock generator settings for one clock capable pin
    typedef struct packed {
        logic       sel;     // 1: pin carries the divided clock
        logic [7:0] period;  // reference cycles per clock period minus one
        logic [7:0] high;    // reference cycles the clock stays high
    } clk_cfg_t;

    localparam clk_cfg_t CLK_CFG_A_RST = '{sel: CLK_SEL_A_RST, period: PERIOD_RST,
                                           high: HIGH_RST};
    localparam clk_cfg_t CLK_CFG_B_RST = '{sel: CLK_SEL_B_RST, period: PERIOD_RST,
                                           high: HIGH_RST};

endpackage

// ===== gpio_port.sv
// module: sixteen pin general purpose input/output port with clock outputs
// Function
// - each pin individually set by software as input or driven output
// - pins 0 to 12 as inputs may each raise a processor interrupt
// - after reset pins 0 to 13 are inputs with drivers off
// - pins 14 and 15 also offer plain input/output like pin 13
// - pins 14 and 15 can output a divided clock with selectable duty cycle
// - on reset pin 14 is an input
// - on reset pin 15 is an output carrying its clock
// - after reset pin 15 clock can clock the expansion interface
module gpio_port
    import gpio_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // software configuration
    input  wire logic [15:0]          dir_out,
    input  wire logic [15:0]          out_val,
    input  wire logic [12:0]          irq_en,
    input  wire clk_cfg_t             clk_cfg_a,
    input  wire clk_cfg_t             clk_cfg_b,
    // software status
    output logic      [15:0]          pin_level,
    output logic                      irq,
    output logic                      pin15_clock_drive,
    // pins
    input  wire logic [15:0]          pin_i,
    output logic      [15:0]          pin_o,
    output logic      [15:0]          pin_oe
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [15:0] dir_q, dir_d;
    logic [15:0] val_q, val_d;
    logic [12:0] ien_q, ien_d;
    clk_cfg_t    cfg_a_q, cfg_a_d;
    clk_cfg_t    cfg_b_q, cfg_b_d;

    always_comb begin
        dir_d   = dir_out;
        val_d   = out_val;
        ien_d   = irq_en;
        cfg_a_d = clk_cfg_a;
        cfg_b_d = clk_cfg_b;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir_q   <= DIR_OUT_RST;
            val_q   <= OUT_VAL_RST;
            ien_q   <= IRQ_EN_RST;
            cfg_a_q <= CLK_CFG_A_RST;
            cfg_b_q <= CLK_CFG_B_RST;
        end else begin
            dir_q   <= dir_d;
            val_q   <= val_d;
            ien_q   <= ien_d;
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [15:0] sync1_q, sync1_d;
    logic [15:0] sync2_q, sync2_d;

    always_comb begin
        sync1_d = pin_i;
        sync2_d = sync1_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_q <= OUT_VAL_RST;
            sync2_q <= OUT_VAL_RST;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ------------------------------------------------------------
    // clock dividers
    // ------------------------------------------------------------
    // next counter value: wrap to zero after the programmed period
    function automatic logic [7:0] next_count(input logic [7:0] cnt, input clk_cfg_t cfg);
        next_count = (cnt >= cfg.period) ? COUNT_ZERO : 8'(cnt + COUNT_ONE);
    endfunction

    // clock level: high for the first high-count cycles of each period
    function automatic logic clk_level(input logic [7:0] cnt, input clk_cfg_t cfg);
        clk_level = (cnt < cfg.high);
    endfunction

    // divided clock level and select, indexed by pin number
    logic [15:0] clk_lvl;
    logic [15:0] clk_sel;

    // pins below the clock capable ones never carry a clock
    assign clk_lvl[CLK_PIN_A-1:0] = OUT_VAL_RST[CLK_PIN_A-1:0];
    assign clk_sel[CLK_PIN_A-1:0] = OUT_VAL_RST[CLK_PIN_A-1:0];

    for (genvar p = CLK_PIN_A; p <= CLK_PIN_B; p++) begin : g_div
        clk_cfg_t   cfg;
        logic [7:0] cnt_q, cnt_d;
        logic       div_q, div_d;

        assign cfg = (p == CLK_PIN_A) ? cfg_a_q : cfg_b_q;

        always_comb begin
            cnt_d = cfg.sel ? next_count(cnt_q, cfg) : COUNT_ZERO;
            div_d = cfg.sel & clk_level(cnt_d, cfg);
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                cnt_q <= COUNT_ZERO;
                div_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                div_q <= div_d;
            end
        end

        assign clk_lvl[p] = div_q;
        assign clk_sel[p] = cfg.sel;
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic [15:0] o_q, o_d;
    logic [15:0] oe_q, oe_d;

    always_comb begin
        o_d  = val_q;
        oe_d = dir_q;
        // a selected clock overrides direction and value of its pin
        for (int i = CLK_PIN_A; i <= CLK_PIN_B; i++) begin
            o_d[i]  = clk_sel[i] ? clk_lvl[i] : val_q[i];
            oe_d[i] = clk_sel[i] | dir_q[i];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            o_q  <= OUT_VAL_RST;
            oe_q <= DIR_OUT_RST;
        end else begin
            o_q  <= o_d;
            oe_q <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // pin level status
    // ------------------------------------------------------------
    logic [15:0] lvl_q, lvl_d;

    always_comb begin
        lvl_d = sync2_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lvl_q <= OUT_VAL_RST;
        end else begin
            lvl_q <= lvl_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt: enabled input pins that read high
    // ------------------------------------------------------------
    logic irq_q, irq_d;

    always_comb begin
        irq_d = |(sync2_q[IRQ_PIN_COUNT-1:0] & ien_q & ~dir_q[IRQ_PIN_COUNT-1:0]);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // copy of the pin 15 clock for the expansion interface
    // ------------------------------------------------------------
    logic p15_q, p15_d;

    always_comb begin
        p15_d = clk_sel[CLK_PIN_B] & clk_lvl[CLK_PIN_B];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            p15_q <= 1'b0;
        end else begin
            p15_q <= p15_d;
        end
    end

    assign pin_o             = o_q;
    assign pin_oe            = oe_q;
    assign pin_level         = lvl_q;
    assign irq               = irq_q;
    assign pin15_clock_drive = p15_q;

endmodule // gpio_port

// ===== gpio_port_props.sv
// checker: pin port timing properties
module gpio_port_props import gpio_pkg::*; (
    // inputs
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [15:0] dir_out,
    input wire logic [15:0] out_val,
    input wire logic [12:0] irq_en,
    input wire clk_cfg_t    clk_cfg_a,
    input wire clk_cfg_t    clk_cfg_b,
    input wire logic [15:0] pin_i,
    // outputs
    input wire logic [15:0] pin_level,
    input wire logic        irq,
    input wire logic        pin15_clock_drive,
    input wire logic [15:0] pin_o,
    input wire logic [15:0] pin_oe
);
    // history of reset, so pipeline checks skip the fill
    logic [3:0] up_q;
    always_ff @(posedge core_clk) up_q <= {up_q[2:0], rst_n};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n || up_q != 4'hF);
    sequence hi3;
        pin15_clock_drive [*3] ##1 !pin15_clock_drive;
    endsequence
    sequence lo_up;
        !pin15_clock_drive ##1 pin15_clock_drive;
    endsequence
    AST_DIR: assert property (pin_oe[13:0] == $past(dir_out[13:0], 2)) else $error("dir");
    AST_VAL: assert property ((pin_oe[13:0] & (pin_o[13:0] ^ $past(out_val[13:0], 2))) == 14'h0)
        else $error("val");
    AST_LVL: assert property (pin_level == $past(pin_i, 3)) else $error("level");
    AST_IRQ: assert property (irq == |($past(pin_i[12:0], 3) & $past(irq_en, 2)
        & ~$past(dir_out[12:0], 2))) else $error("irq");
    AST_P14: assert property (!$past(clk_cfg_a.sel, 2) |-> pin_oe[14] == $past(dir_out[14], 2))
        else $error("p14");
    AST_P15: assert property ($past(clk_cfg_b.sel, 2) |-> pin_oe[15] && pin_o[15]
        == pin15_clock_drive) else $error("p15");
    AST_DIV: assert property ($rose(pin15_clock_drive) && clk_cfg_b == 17'h10403
        && clk_cfg_b == $past(clk_cfg_b, 8) |-> hi3 ##1 lo_up) else $error("div");
    AST_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
        up_q == 4'h7 |-> pin_oe == 16'h8000) else $error("rst");
endmodule // gpio_port_props
bind gpio_port gpio_port_props u_props (.*);

// ===== pin_board.sv
// board model: drives pins, pull-up on undriven pins
module pin_board (
    // port side
    input wire logic [15:0] pin_o,
    input wire logic [15:0] pin_oe,
    // board side
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_oe,
    output logic     [15:0] pin_i
);
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule // pin_board

// ===== tb.sv
// testbench: pin port directed tests
module tb import gpio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] dir_out = 16'h0000;
    logic [15:0] out_val = 16'h0000;
    logic [15:0] ext_val = 16'h0000;
    logic [15:0] ext_oe = 16'hFFFF;
    logic [12:0] irq_en = 13'h0000;
    clk_cfg_t    cfg_a = CLK_CFG_A_RST;
    clk_cfg_t    cfg_b = CLK_CFG_B_RST;
    logic [15:0] pin_level, pin_o, pin_oe, pin_i;
    logic        irq, drive15, prev;
    int          fails = 0, checked = 0, n, m;
    always #20 core_clk = ~core_clk;
    pin_board u_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe),
        .pin_i(pin_i));
    gpio_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .dir_out(dir_out), .out_val(out_val),
        .irq_en(irq_en), .clk_cfg_a(cfg_a), .clk_cfg_b(cfg_b), .pin_level(pin_level),
        .irq(irq), .pin15_clock_drive(drive15), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    // board drives every pin the port leaves as input
    task automatic put(input logic [15:0] d, v, e, input logic [12:0] q);
        @(posedge core_clk);
        dir_out <= d;
        out_val <= v;
        ext_val <= e;
        ext_oe <= ~d;
        irq_en <= q;
        repeat (5) @(posedge core_clk);
        #1;
    endtask
    task automatic wrap_up;
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #40000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(pin_oe, 16'h8000);
        prev = drive15;
        @(posedge core_clk);
        #1;
        chk({15'h0, drive15 ^ prev}, 16'h0001);
        put(16'h2AAA, 16'h0A0A, 16'h1555, 13'h0000);
        chk(pin_oe, 16'hAAAA);
        chk(pin_o & pin_oe & 16'h3FFF, 16'h0A0A);
        chk(pin_level & 16'h7FFF, 16'h1F5F);
        put(16'h0000, 16'h0000, 16'h0001, 13'h0001);
        chk({15'h0, irq}, 16'h0001);
        put(16'h0001, 16'h0000, 16'h0001, 13'h0001);
        chk({15'h0, irq}, 16'h0000);
        put(16'h0000, 16'h0000, 16'h1000, 13'h0FFF);
        chk({15'h0, irq}, 16'h0000);
        put(16'h0000, 16'h0000, 16'h1000, 13'h1000);
        chk({15'h0, irq}, 16'h0001);
        @(posedge core_clk);
        cfg_a <= 17'h00101;
        cfg_b <= 17'h00101;
        put(16'hC000, 16'h4000, 16'h0000, 13'h0000);
        chk(pin_oe, 16'hC000);
        chk(pin_o & pin_oe, 16'h4000);
        @(posedge core_clk);
        cfg_a <= 17'h10401;
        cfg_b <= 17'h10403;
        put(16'h0000, 16'h0000, 16'h0000, 13'h0000);
        chk(pin_oe, 16'hC000);
        n = 0;
        m = 0;
        repeat (10) begin
            @(posedge core_clk);
            #1;
            n += pin_o[14];
            m += pin_o[15];
        end
        chk(16'(n), 16'h0002);
        chk(16'(m), 16'h0006);
        wrap_up();
    end
endmodule // tb
